//--- common/urx_pkg.sv
// Purpose: Constants and types for the serial receive, error and wake block.
// Assumes: 32-bit Avalon-MM register window, byte addresses, one word per register.
// Notes:   Transmitter status enters as plain levels; only its status bits and interrupt gating live here.
// How it works
// [R1] Noise flag rises with data-available; word still stored
// [R2] Noise clears after status read, buffer read
// [R3] Low stop bit sets framing error
// [R4] Framing error stored with word; reset clears
// [R5] Parity mismatch sets parity error when enabled
// [R6] Parity error stored with word; reset clears
// [R7] Software reads word flags before the word
// [R8] Six interrupt sources feed the request
// [R9] Request is an active-low one-cycle pulse
// [R10] Own enables for transmit, shared receive enable
// [R11] Address detect interrupts, no flag
// [R12] Receive-line wake interrupts, no flag
// [R13] Status flags read-only, cleared by accesses
// [R14] Address mode: interrupt only on high msb
// [R15] Without address mode: interrupt every word
// [R16] Software disables parity in address mode
// [R17] Stopped clock freezes all receive activity
// [R18] Power-down leaves all registers unchanged
// [R19] Software lets transfers finish before power-down
// [R20] Enabled falling receive edge wakes processor
// [R21] Ignore receive data during start-up interval
// [R22] Wake interrupt needs global, port enables
// [R23] Three-sample majority at sixteen times baud
// [R24] Overrun sets flag, keeps buffer, drops word
// [R25] Outer enables mask request, flags untouched
package urx_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_STATUS   = 5'h00;
  localparam logic [4:0] OFS_CTRL_ONE = 5'h04;
  localparam logic [4:0] OFS_CTRL_TWO = 5'h08;
  localparam logic [4:0] OFS_RX_BUF   = 5'h0C;
  localparam logic [4:0] OFS_BAUD     = 5'h10;

  // Status register bit positions
  localparam int ST_AVAIL = 0;
  localparam int ST_OVR   = 1;
  localparam int ST_FRM   = 2;
  localparam int ST_PAR   = 3;
  localparam int ST_NOISE = 4;
  localparam int ST_RIDLE = 5;
  localparam int ST_TIDLE = 6;
  localparam int ST_TEMPTY = 7;

  // Control one bit positions (bit 0 is the read-only ninth data bit)
  localparam int C1_RX8    = 0;
  localparam int C1_STOP2  = 3;
  localparam int C1_ODD    = 4;
  localparam int C1_PAR_ON = 5;
  localparam int C1_NINE   = 6;
  localparam int C1_PORT   = 7;

  // Control two bit positions
  localparam int C2_RX_ON  = 2;
  localparam int C2_ADDR   = 3;
  localparam int C2_WAKE   = 4;
  localparam int C2_RXIE   = 5;
  localparam int C2_TIIE   = 6;
  localparam int C2_TEIE   = 7;

  // Reset values
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] BAUD_RST     = 8'h00;

  // Oversampling: sixteen ticks per bit, votes at ticks 7, 8, 9
  localparam logic [3:0] OS_FIRST = 4'h7;
  localparam logic [3:0] OS_LAST  = 4'hF;

  // Start-up interval after a wake, in system clock cycles
  localparam logic [10:0] STARTUP_CYC = 11'h400;

  // Receiver states
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP1, RX_STOP2, RX_WAIT_HIGH} urx_state_t;

  // Buffered word: parity error, framing error, nine data bits
  typedef logic [10:0] urx_entry_t;

endpackage

//--- verilog/urx_core.sv
// Purpose: Serial receiver with error flags, two-word buffer, interrupt pulse and line wake.
// Assumes: All inputs synchronous to clk_sys_i; 20 MHz system clock; pwr_down_i marks a stopped clock.
// Notes:   Registers answer one cycle after a request is seen; waitrequest is high in between.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module urx_core (
  input  wire logic        clk_sys_i,       // System clock
  input  wire logic        rst_i,           // Synchronous reset, active high
  input  wire logic [4:0]  address_i,       // Avalon byte address
  input  wire logic        read_i,          // Avalon read
  input  wire logic        write_i,         // Avalon write
  input  wire logic [3:0]  byteenable_i,    // Avalon byte enables
  input  wire logic [31:0] writedata_i,     // Avalon write data
  output logic      [31:0] readdata_o,      // Avalon read data
  output logic             waitrequest_o,   // Avalon wait
  input  wire logic        rx_i,            // Serial receive line
  input  wire logic        tx_empty_i,      // Transmit buffer empty level
  input  wire logic        tx_idle_i,       // Transmitter idle level
  input  wire logic        global_irq_enable_i, // Processor global enable
  input  wire logic        port_irq_enable_i,   // Interrupt-controller enable for this port
  input  wire logic        pwr_down_i,      // Processor in power-down
  output logic             wake_o,          // Wake request pulse
  output logic             irq_n_o          // Interrupt request, active low pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // State record
  typedef struct packed {
    logic                        ack;        // Bus answer cycle
    logic [31:0]                 rdata;      // Registered read data
    logic [7:0]                  ctrl1;      // Control one (bit 0 unused here)
    logic [7:0]                  ctrl2;      // Control two
    logic [7:0]                  baud;       // Baud divisor
    logic                        armed;      // Status access seen
    logic                        noise;      // Sticky noise flag
    logic                        ovr;        // Sticky overrun flag
    logic [1:0]                  cnt;        // Words buffered
    logic                        wp;         // Write slot
    logic                        rp;         // Read slot
    logic [1:0][10:0]            fifo;       // Two-word buffer
    urx_pkg::urx_state_t         rstate;     // Receiver state
    logic [7:0]                  tick_cnt;   // Divider toward 16x tick
    logic [3:0]                  os_cnt;     // Tick within bit
    logic [2:0]                  votes;      // Three line samples
    logic [3:0]                  bitn;       // Data bit index
    logic [8:0]                  shift;      // Receive shift register
    logic                        par_bit;    // Received parity bit
    logic                        noisy;      // Noise seen in this frame
    logic                        rx_prev;    // Line one cycle ago
    logic                        txe_prev;   // Transmit empty one cycle ago
    logic                        txi_prev;   // Transmit idle one cycle ago
    logic [10:0]                 startup;    // Start-up counter
    logic                        starting;   // Start-up interval running
    logic                        irq_n;      // Interrupt pulse
    logic                        wake;       // Wake pulse
  } urx_core_state_t;

  urx_core_state_t st;       // Registered state
  urx_core_state_t next_st;  // Next state

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Majority of three samples
  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  // Most significant received bit for the word length in force
  function automatic logic word_msb(input logic [8:0] w, input logic nine);
    word_msb = nine ? w[8] : w[7];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic req;           // Bus request present
    logic take;          // Request accepted this edge
    logic hit_rd_buf;    // Accepted receive buffer read
    logic pop;           // Word leaves the buffer
    logic tick;          // 16x oversampling tick
    logic v;             // Voted bit
    logic done;          // Frame complete
    logic bad_stop;      // Framing error of frame
    logic bad_par;       // Parity error of frame
    logic push;          // Word enters the buffer
    logic ovr_evt;       // Overrun happened
    logic avail_evt;     // Qualified data-available event
    logic wake_ok;       // Wake conditions met
    logic wake_irq;      // Wake interrupt event
    logic run;           // Receiver allowed to run
    logic ev;            // Any enabled interrupt event
    urx_pkg::urx_entry_t head; // Oldest buffered word
    req = 1'b0;
    take = 1'b0;
    hit_rd_buf = 1'b0;
    pop = 1'b0;
    tick = 1'b0;
    v = 1'b0;
    done = 1'b0;
    bad_stop = 1'b0;
    bad_par = 1'b0;
    push = 1'b0;
    ovr_evt = 1'b0;
    avail_evt = 1'b0;
    wake_irq = 1'b0;
    next_st = st;
    head = st.fifo[st.rp];

    // Bus slave: answer one cycle after the request appears
    req = read_i | write_i;
    take = req & st.ack;
    next_st.ack = req & ~st.ack;
    if (req && !st.ack) begin
      next_st.rdata = 32'h0000_0000;
      if (address_i == urx_pkg::OFS_STATUS) begin
        next_st.rdata[urx_pkg::ST_AVAIL] = (st.cnt != 2'h0);
        next_st.rdata[urx_pkg::ST_OVR]   = st.ovr;
        next_st.rdata[urx_pkg::ST_FRM]   = (st.cnt != 2'h0) & head[9];   // [R4]
        next_st.rdata[urx_pkg::ST_PAR]   = (st.cnt != 2'h0) & head[10];  // [R6]
        next_st.rdata[urx_pkg::ST_NOISE] = st.noise;
        next_st.rdata[urx_pkg::ST_RIDLE] = (st.rstate == urx_pkg::RX_IDLE);
        next_st.rdata[urx_pkg::ST_TIDLE] = tx_idle_i;
        next_st.rdata[urx_pkg::ST_TEMPTY] = tx_empty_i;
      end else if (address_i == urx_pkg::OFS_CTRL_ONE) begin
        next_st.rdata[7:0] = {st.ctrl1[7:1], head[8]};
      end else if (address_i == urx_pkg::OFS_CTRL_TWO) begin
        next_st.rdata[7:0] = st.ctrl2;
      end else if (address_i == urx_pkg::OFS_RX_BUF) begin
        next_st.rdata[7:0] = head[7:0];
      end else if (address_i == urx_pkg::OFS_BAUD) begin
        next_st.rdata[7:0] = st.baud;
      end
    end

    // Writes land at the accepting edge; status is not writable
    if (take && write_i && byteenable_i[0]) begin  // [R13]
      if (address_i == urx_pkg::OFS_CTRL_ONE) begin
        next_st.ctrl1 = {writedata_i[7:1], 1'b0};
      end else if (address_i == urx_pkg::OFS_CTRL_TWO) begin
        next_st.ctrl2 = writedata_i[7:0];
      end else if (address_i == urx_pkg::OFS_BAUD) begin
        next_st.baud = writedata_i[7:0];
      end
    end

    // Clearing sequence: status access arms, buffer read completes it
    hit_rd_buf = take & read_i & (address_i == urx_pkg::OFS_RX_BUF);
    if (take && address_i == urx_pkg::OFS_STATUS) begin
      next_st.armed = 1'b1;
    end else if (hit_rd_buf) begin
      next_st.armed = 1'b0;
    end
    if (hit_rd_buf && st.armed) begin
      next_st.noise = 1'b0;                               // [R2]
      next_st.ovr = 1'b0;                                 // [R24]
      pop = (st.cnt != 2'h0);
    end
    if (pop) begin
      next_st.rp = ~st.rp;
    end

    // A stopped clock freezes the receiver; nothing else changes
    run = st.ctrl1[urx_pkg::C1_PORT] & st.ctrl2[urx_pkg::C2_RX_ON] & ~pwr_down_i & ~st.starting; // [R17] [R18]

    // Oversampling tick from the baud divisor
    if (pwr_down_i) begin
      tick = 1'b0;
    end else if (st.tick_cnt >= st.baud) begin
      tick = 1'b1;
      next_st.tick_cnt = 8'h00;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 8'h01;
    end

    // Receiver: three votes mid-bit, decided on the last tick
    v = maj3(st.votes);                                   // [R23]
    if (!run) begin
      if (!pwr_down_i) begin
        next_st.rstate = urx_pkg::RX_IDLE;                // [R21]
      end
    end else if (tick) begin
      if (st.rstate == urx_pkg::RX_IDLE) begin
        if (!rx_i) begin
          next_st.rstate = urx_pkg::RX_START;
          next_st.os_cnt = 4'h0;
          next_st.noisy = 1'b0;
        end
      end else if (st.rstate == urx_pkg::RX_WAIT_HIGH) begin
        if (rx_i) begin
          next_st.rstate = urx_pkg::RX_IDLE;              // Break ends only on a high line
        end
      end else begin
        next_st.os_cnt = st.os_cnt + 4'h1;
        if (st.os_cnt >= urx_pkg::OS_FIRST && st.os_cnt < urx_pkg::OS_FIRST + 4'h3) begin
          next_st.votes[2'(st.os_cnt - urx_pkg::OS_FIRST)] = rx_i; // [R23]
        end
        if (st.os_cnt == urx_pkg::OS_LAST) begin
          if (st.votes != 3'h0 && st.votes != 3'h7) begin
            next_st.noisy = 1'b1;                         // [R23]
          end
          case (st.rstate)
            urx_pkg::RX_START: begin
              next_st.rstate = v ? urx_pkg::RX_IDLE : urx_pkg::RX_DATA;
              next_st.bitn = 4'h0;
            end
            urx_pkg::RX_DATA: begin
              next_st.shift[st.bitn] = v;
              next_st.bitn = st.bitn + 4'h1;
              if (st.bitn == (st.ctrl1[urx_pkg::C1_NINE] ? 4'h8 : 4'h7)) begin
                if (st.ctrl1[urx_pkg::C1_PAR_ON]) begin
                  next_st.rstate = urx_pkg::RX_PARITY;
                end else begin
                  next_st.rstate = urx_pkg::RX_STOP1;
                end
              end
            end
            urx_pkg::RX_PARITY: begin
              next_st.par_bit = v;
              next_st.rstate = urx_pkg::RX_STOP1;
            end
            urx_pkg::RX_STOP1: begin
              if (v && st.ctrl1[urx_pkg::C1_STOP2]) begin
                next_st.rstate = urx_pkg::RX_STOP2;
              end else begin
                done = 1'b1;
                bad_stop = ~v;                            // [R3]
              end
            end
            urx_pkg::RX_STOP2: begin
              done = 1'b1;
              bad_stop = ~v;                              // [R3]
            end
            default: begin
              next_st.rstate = urx_pkg::RX_IDLE;
            end
          endcase
        end
      end
    end

    // Frame end: store the word with its own error bits
    if (done) begin
      next_st.rstate = bad_stop ? urx_pkg::RX_WAIT_HIGH : urx_pkg::RX_IDLE;
      if (!st.ctrl1[urx_pkg::C1_NINE]) begin
        next_st.shift[8] = 1'b0;
      end
      bad_par = st.ctrl1[urx_pkg::C1_PAR_ON]
             & ((^next_st.shift) ^ st.par_bit ^ st.ctrl1[urx_pkg::C1_ODD]); // [R5]
      if (st.cnt == 2'h2) begin
        ovr_evt = 1'b1;                                   // [R24]
        next_st.ovr = 1'b1;
      end else begin
        push = 1'b1;
        next_st.fifo[st.wp] = {bad_par, bad_stop, next_st.shift}; // [R4] [R6]
        next_st.wp = ~st.wp;
        if (next_st.noisy) begin
          next_st.noise = 1'b1;                           // [R1]
        end
        avail_evt = ~st.ctrl2[urx_pkg::C2_ADDR]           // [R15]
                    | word_msb(next_st.shift, st.ctrl1[urx_pkg::C1_NINE]); // [R14] [R11]
      end
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};

    // Receive-line wake and start-up interval
    wake_ok = st.ctrl2[urx_pkg::C2_WAKE] & st.ctrl1[urx_pkg::C1_PORT]
              & st.ctrl2[urx_pkg::C2_RX_ON] & st.ctrl2[urx_pkg::C2_RXIE];
    next_st.rx_prev = rx_i;
    next_st.wake = pwr_down_i & wake_ok & st.rx_prev & ~rx_i; // [R20]
    if (st.wake) begin
      next_st.starting = 1'b1;
      next_st.startup = 11'h000;
    end else if (st.starting) begin
      if (st.startup == urx_pkg::STARTUP_CYC - 11'h001) begin
        next_st.starting = 1'b0;
        wake_irq = st.ctrl2[urx_pkg::C2_WAKE] & st.ctrl2[urx_pkg::C2_RXIE]; // [R12] [R21]
      end else begin
        next_st.startup = st.startup + 11'h001;
      end
    end

    // Interrupt pulse from the six sources
    next_st.txe_prev = tx_empty_i;
    next_st.txi_prev = tx_idle_i;
    ev = (tx_empty_i & ~st.txe_prev & st.ctrl2[urx_pkg::C2_TEIE])   // [R10]
       | (tx_idle_i & ~st.txi_prev & st.ctrl2[urx_pkg::C2_TIIE])    // [R10]
       | ((avail_evt | ovr_evt) & st.ctrl2[urx_pkg::C2_RXIE])       // [R10] [R8]
       | wake_irq;
    next_st.irq_n = ~(ev & global_irq_enable_i & port_irq_enable_i); // [R9] [R22] [R25]
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      next_st_reset();
    end else begin
      st <= next_st;
    end
  end

  // Reset values of the whole record
  task automatic next_st_reset();
    st          <= '0;
    st.ctrl1    <= urx_pkg::CTRL_ONE_RST;
    st.ctrl2    <= urx_pkg::CTRL_TWO_RST;
    st.baud     <= urx_pkg::BAUD_RST;
    st.rstate   <= urx_pkg::RX_IDLE;
    st.rx_prev  <= 1'b1;
    st.txe_prev <= 1'b1;
    st.txi_prev <= 1'b1;
    st.irq_n    <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign readdata_o    = st.rdata;
  assign waitrequest_o = (read_i | write_i) & ~st.ack;
  assign wake_o        = st.wake;
  assign irq_n_o       = st.irq_n;

endmodule

//--- bench/urx_assertions.sv
// Purpose: Port-level checks for the serial receive, error and wake block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to urx_core from the bench top file.
`timescale 1ns/1ps
module urx_assertions (
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  input wire logic [4:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        rx_i,
  input wire logic        global_irq_enable_i,
  input wire logic        port_irq_enable_i,
  input wire logic        pwr_down_i,
  input wire logic        wake_o,
  input wire logic        irq_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////
  // Cycles since the last wake pulse; saturates so it never wraps into a false window
  logic [10:0] since_wake;
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      since_wake <= 11'h000;
    end else if (wake_o) begin
      since_wake <= 11'h001;
    end else if (since_wake != 11'h000 && since_wake != 11'h7FF) begin
      since_wake <= since_wake + 11'h001;
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_wait_one;
    ($rose(read_i) || $rose(write_i)) |-> waitrequest_o ##1 !waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait");
  property p_read_high;
    read_i && !waitrequest_o |-> readdata_o[31:8] == 24'h000000;
  endproperty
  a_read_high: assert property (p_read_high) else $error("read data upper bits set");
  property p_unmapped;
    read_i && !waitrequest_o && address_i > 5'h13 |-> readdata_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_irq_mask;
    (!(global_irq_enable_i && port_irq_enable_i))[*3] |-> irq_n_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("request while masked");
  property p_wake_cause;
    wake_o |-> $past(pwr_down_i) && !$past(rx_i);
  endproperty
  a_wake_cause: assert property (p_wake_cause) else $error("wake without low line in power-down");
  property p_wake_pulse;
    wake_o |=> !wake_o;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
  property p_startup_quiet;
    since_wake != 11'h000 && since_wake < 11'h401 |-> irq_n_o;
  endproperty
  a_startup_quiet: assert property (p_startup_quiet) else $error("request during start-up");
  property p_pdown_quiet;
    pwr_down_i[*3] |-> irq_n_o;
  endproperty
  a_pdown_quiet: assert property (p_pdown_quiet) else $error("request with clock stopped");
  property p_reset_clear;
    disable iff (1'b0) rst_i |=> irq_n_o && !wake_o && readdata_o == 32'h00000000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
  // Main scenarios reached
  c_irq: cover property (!irq_n_o);
  c_wake: cover property (wake_o);
  c_read: cover property (read_i && !waitrequest_o);
endmodule

//--- bench/urx_line_model.sv
// Purpose: Remote serial transmitter driving the receive line.
// Assumes: The bench hands a whole frame, start bit in bit 0, LSB first.
// Notes:   Line idles high like a pulled-up wire; optional one-cycle glitch.
`timescale 1ns/1ps
module urx_line_model #(
  parameter int BIT_CYC = 16
) (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [12:0] bits_i,
  input  wire logic [3:0]  len_i,
  input  wire logic        glitch_i,
  output logic             line_o,
  output logic             busy_o
);
  logic [12:0] sh;   // Frame being sent
  logic [3:0]  len;  // Bits in frame
  logic        gl;   // Glitch wanted
  int          fc;   // Cycles into frame
  int          nx;   // Bit shown next cycle
  initial begin
    line_o = 1'b1;
    busy_o = 1'b0;
    fc = 0;
  end
  // Glitch sits mid first data bit so only one of the three votes disagrees
  always @(posedge clk_i) begin
    nx = (fc + 1) / BIT_CYC;
    if (!busy_o && go_i) begin
      sh <= bits_i;
      len <= len_i;
      gl <= glitch_i;
      fc <= 0;
      busy_o <= 1'b1;
      line_o <= bits_i[0];
    end else if (busy_o) begin
      fc <= fc + 1;
      if (nx >= len) begin
        busy_o <= 1'b0;
        line_o <= 1'b1;
      end else begin
        line_o <= sh[nx] ^ (gl && fc + 1 == BIT_CYC + 8);
      end
    end
  end
endmodule

//--- bench/tb.sv
// Purpose: Self-checking bench for the serial receive, error and wake block.
// Assumes: Baud divisor 0, so one bit lasts sixteen system clocks.
// Notes:   Random frame settings from a fixed seed, with corner cases forced.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module tb;
  logic        clk_sys_i, rst_i, read_i, write_i, rx_i, waitrequest_o, wake_o, irq_n_o;
  logic        tx_empty_i, tx_idle_i, global_irq_enable_i, port_irq_enable_i, pwr_down_i;
  logic [4:0]  address_i;
  logic [3:0]  byteenable_i, ln;
  logic [31:0] writedata_i, readdata_o;
  logic [12:0] bits;
  logic        go, glitch, busy;
  logic [7:0]  q, b, dv[3];
  logic [8:0]  d;
  logic [14:0] r;
  int          mismatches, comparisons, irqs, n;
  urx_core urx_core_i (.clk_sys_i, .rst_i, .address_i, .read_i, .write_i, .byteenable_i, .writedata_i,
    .readdata_o, .waitrequest_o, .rx_i, .tx_empty_i, .tx_idle_i, .global_irq_enable_i,
    .port_irq_enable_i, .pwr_down_i, .wake_o, .irq_n_o);
  urx_line_model #(.BIT_CYC(16)) urx_line_model_i (.clk_i(clk_sys_i), .go_i(go), .bits_i(bits),
    .len_i(ln), .glitch_i(glitch), .line_o(rx_i), .busy_o(busy));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  // Count request cycles seen low
  always @(posedge clk_sys_i) if (!rst_i && irq_n_o === 1'b0) irqs++;
  ////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] dt, output logic [7:0] rd);
    @(posedge clk_sys_i);
    address_i <= a;
    writedata_i <= {24'h000000, dt};
    write_i <= wr;
    read_i <= !wr;
    // Hold until the edge where wait is seen low
    do @(posedge clk_sys_i); while (waitrequest_o !== 1'b0);
    rd = readdata_o[7:0];
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  // Frame: start, data LSB first, parity, stops; length in the top nibble
  function automatic logic [16:0] mk(input logic [8:0] dt, input logic nine, par, odd, st2, bp, bs);
    logic [12:0] f;
    int k;
    f = 13'h1FFE;
    k = 1;
    for (int i = 0; i < (nine ? 9 : 8); i++) f[k++] = dt[i];
    if (par) f[k++] = ^(nine ? dt : {1'b0, dt[7:0]}) ^ odd ^ bp;
    k += st2 ? 2 : 1;
    if (bs) f[k-1] = 1'b0;
    return {4'(k), f};
  endfunction
  task automatic launch(input logic [16:0] f, input logic gl);
    @(posedge clk_sys_i);
    go <= 1'b1;
    bits <= f[12:0];
    ln <= f[16:13];
    glitch <= gl;
    @(posedge clk_sys_i);
    go <= 1'b0;
  endtask
  task automatic send(input logic [16:0] f, input logic gl);
    launch(f, gl);
    do @(negedge clk_sys_i); while (busy === 1'b1);
    repeat (20) @(posedge clk_sys_i);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    mismatches++;
    summarize();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {read_i, write_i, go, glitch, pwr_down_i, tx_empty_i, tx_idle_i} = '0;
    {global_irq_enable_i, port_irq_enable_i, rst_i} = 3'b111;
    address_i = 5'h00;
    writedata_i = 32'h00000000;
    byteenable_i = 4'hF;
    bits = 13'h1FFF;
    ln = 4'h0;
    {mismatches, comparisons, irqs} = '0;
    void'($urandom(73016));
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    // Reset values, unmapped places, read-only status
    for (int a = 1; a < 8; a++) if (a != 3) begin
      bus(0, 5'(a * 4), 8'h00, q);
      `CHK("reset_value", 8'h00, q)
    end
    bus(1, 5'h00, 8'hFF, q);
    bus(1, 5'h14, 8'hFF, q);
    bus(0, 5'h00, 8'h00, q);
    `CHK("status_ro", 8'h20, q)
    b = $urandom;
    bus(1, 5'h10, b, q);
    bus(0, 5'h10, 8'h00, q);
    `CHK("baud", b, q)
    bus(1, 5'h10, 8'h00, q);
    $display("test registers done");
    // Random frames; first one has its second stop bit low
    for (int k = 0; k < 14; k++) begin
      d = $urandom;
      r = $urandom;
      if (k == 0) r[6:3] = 4'hF;
      if (r[10:9] == 2'b11) r[1] = 1'b0;
      bus(1, 5'h04, {1'b1, r[0], &r[1:0], r[2], r[3], 3'b000}, q);
      bus(1, 5'h08, {3'b001, 1'b0, r[10:9] == 2'b11, 3'b100}, q);
      global_irq_enable_i <= r[11] | r[12];
      port_irq_enable_i <= r[13] | r[14];
      irqs = 0;
      send(mk(d, r[0], r[1] & r[0], r[2], r[3], r[4] & r[1] & r[0], r[5] & r[6]), r[7] & r[8]);
      `CHK("irq_count", ((r[11] | r[12]) && (r[13] | r[14]) && (r[10:9] != 2'b11 || d[r[0] ? 8 : 7])) ? 1 : 0, irqs)
      bus(0, 5'h04, 8'h00, q);
      `CHK("ninth_bit", r[0] & d[8], q[0])
      bus(0, 5'h00, 8'h00, q);
      `CHK("status", {tx_empty_i, tx_idle_i, 1'b1, r[7] & r[8], r[4] & r[1] & r[0], r[5] & r[6], 2'b01}, q)
      bus(0, 5'h0C, 8'h00, q);
      `CHK("data", d[7:0], q)
      bus(0, 5'h00, 8'h00, q);
      `CHK("status_popped", 8'h20, q)
    end
    $display("test frames done");
    // Third word into a full buffer
    global_irq_enable_i <= 1'b0;
    bus(1, 5'h04, 8'h80, q);
    for (int j = 0; j < 3; j++) begin
      dv[j] = $urandom;
      send(mk({1'b0, dv[j]}, 0, 0, 0, 0, 0, 0), 1'b0);
    end
    bus(0, 5'h00, 8'h00, q);
    `CHK("overrun_status", 8'h23, q)
    bus(0, 5'h0C, 8'h00, q);
    `CHK("kept_first", dv[0], q)
    bus(0, 5'h00, 8'h00, q);
    `CHK("overrun_cleared", 8'h21, q)
    bus(0, 5'h0C, 8'h00, q);
    `CHK("kept_second", dv[1], q)
    $display("test overrun done");
    // Each transmit source under its own enable
    {global_irq_enable_i, port_irq_enable_i} <= 2'b11;
    for (int j = 0; j < 2; j++) begin
      bus(1, 5'h08, 8'(8'h40 << j) | 8'h04, q);
      tx_empty_i <= 1'b0;
      tx_idle_i <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      irqs = 0;
      tx_empty_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      tx_idle_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      `CHK("tx_irq", 1, irqs)
    end
    $display("test transmit sources done");
    // Line wake, with and without the global enable
    for (int j = 0; j < 2; j++) begin
      bus(1, 5'h08, 8'h34, q);
      global_irq_enable_i <= j[0];
      pwr_down_i <= 1'b1; // Line and receiver idle here
      repeat (3) @(posedge clk_sys_i);
      irqs = 0;
      launch(mk(9'h055, 0, 0, 0, 0, 0, 0), 1'b0);
      n = 0;
      do @(negedge clk_sys_i); while (wake_o !== 1'b1 && n++ < 200);
      `CHK("wake", 1'b1, wake_o)
      @(posedge clk_sys_i);
      pwr_down_i <= 1'b0;
      repeat (1300) @(posedge clk_sys_i);
      `CHK("wake_irq", j, irqs)
      bus(0, 5'h00, 8'h00, q);
      `CHK("wake_data_ignored", 8'hE0, q)
      bus(0, 5'h08, 8'h00, q);
      `CHK("ctrl_two_kept", 8'h34, q)
      bus(0, 5'h04, 8'h00, q);
      `CHK("ctrl_one_kept", 8'h80, q)
    end
    $display("test wake done");
    summarize();
  end
endmodule
bind urx_core urx_assertions urx_assertions_i (.clk_sys_i, .rst_i, .address_i, .read_i, .write_i,
  .readdata_o, .waitrequest_o, .rx_i, .global_irq_enable_i, .port_irq_enable_i, .pwr_down_i,
  .wake_o, .irq_n_o);
